// ### src/sls_pkg.sv
// Shared constants, field layout and helpers of the setpoint list sequencer.
// Assumes one 100 MHz clock; dwell is held in units of 100 us.
package sls_pkg;
  localparam int VAL_W = 16;
  localparam int IDX_W = 10;
  localparam int DWELL_W = 16;
  localparam int LOOP_W = 9;
  localparam int ENTRY_W = 2 * VAL_W + DWELL_W;
  localparam int TABLE_DEPTH = 1000;
  localparam logic [IDX_W-1:0] STEP_MAX = 10'h3E8;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 9'h100;
  localparam logic [LOOP_W-1:0] LOOP_CONT = 9'h000;
  // Entry fields: voltage, current, dwell
  localparam int ENT_VOLT_LSB = VAL_W + DWELL_W;
  localparam int ENT_CURR_LSB = DWELL_W;
  localparam int ENT_DWELL_LSB = 0;
  // Reset values of the setpoints
  localparam logic [VAL_W-1:0] VOLT_ZERO = 16'h0000;
  localparam logic [VAL_W-1:0] CURR_MIN = 16'h0000;
  // Times in seconds and the derived counts
  localparam real CLK_HZ = 100.0e6;
  localparam real DWELL_UNIT_S = 0.0001;
  localparam real WEB_DWELL_MIN_S = 0.1;
  localparam real WEB_DWELL_MAX_S = 5.0;
  localparam real CMD_DWELL_MIN_S = 0.01;
  localparam real RAMP_DWELL_MIN_S = 0.0005;
  localparam int TICK_CYC_DEF = int'(DWELL_UNIT_S * CLK_HZ);
  localparam logic [DWELL_W-1:0] WEB_DWELL_MIN = DWELL_W'(int'(WEB_DWELL_MIN_S / DWELL_UNIT_S));
  localparam logic [DWELL_W-1:0] WEB_DWELL_MAX = DWELL_W'(int'(WEB_DWELL_MAX_S / DWELL_UNIT_S));
  localparam logic [DWELL_W-1:0] CMD_DWELL_MIN = DWELL_W'(int'(CMD_DWELL_MIN_S / DWELL_UNIT_S));
  localparam logic [DWELL_W-1:0] RAMP_DWELL_MIN = DWELL_W'(int'(RAMP_DWELL_MIN_S / DWELL_UNIT_S));

  function automatic logic [VAL_W-1:0] sls_abs(input logic [VAL_W-1:0] v);
    sls_abs = v[VAL_W-1] ? VAL_W'(~v + 16'h0001) : v;
  endfunction
endpackage

// ### src/sls_ramp_gen.sv
// Ramp generator: divides total time by step count, then emits each point.
// Assumes the caller has checked table space, limits and the total time.
`timescale 1ns/1ns
`default_nettype none
module sls_ramp_gen
  import sls_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [VAL_W-1:0] from_in,
  input wire logic [VAL_W-1:0] to_in,
  input wire logic [IDX_W-1:0] count_in,
  input wire logic [DWELL_W-1:0] time_in,
  output logic busy_out,
  output logic step_valid_out,
  output logic [VAL_W-1:0] step_val_out,
  output logic [DWELL_W-1:0] step_dwell_out,
  output logic refused_out
);
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_DIV = 2'b10} sls_ramp_t;
  sls_ramp_t state;
  logic phase;
  logic [31:0] num;
  logic [16:0] rem;
  logic [15:0] den;
  logic [4:0] bitcnt;
  logic [IDX_W-1:0] n, k;
  logic [VAL_W-1:0] from_q, to_q;

  // Shared shift-subtract divider; a single one keeps area small at 32 cycles a point
  wire [16:0] rem_sh = {rem[15:0], num[31]};
  wire ge = rem_sh >= {1'b0, den};
  wire [31:0] q_fin = {num[30:0], ge};
  wire div_last = (state == R_DIV) && (bitcnt == 5'h1F);
  wire [16:0] diff = {to_q[VAL_W-1], to_q} - {from_q[VAL_W-1], from_q};
  wire down = diff[16];
  wire [16:0] mag = down ? 17'(~diff + 17'h00001) : diff;
  wire [IDX_W-1:0] k_next = phase ? IDX_W'(k + 10'h001) : 10'h000;
  wire [31:0] val_num = 32'(mag * k_next);
  wire [15:0] val_den = (n == 10'h001) ? 16'h0001 : 16'(n - 10'h001);
  wire dwell_bad = div_last && !phase && (q_fin <= 32'(RAMP_DWELL_MIN));
  wire pt_last = div_last && phase && (k == IDX_W'(n - 10'h001));
  wire [16:0] pt_val = down ? 17'({from_q[VAL_W-1], from_q} - q_fin[16:0])
                            : 17'({from_q[VAL_W-1], from_q} + q_fin[16:0]);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= R_IDLE;
      phase <= 1'b0;
      num <= 32'h00000000;
      rem <= 17'h00000;
      den <= 16'h0001;
      bitcnt <= 5'h00;
      n <= 10'h000;
      k <= 10'h000;
      from_q <= 16'h0000;
      to_q <= 16'h0000;
      busy_out <= 1'b0;
      step_valid_out <= 1'b0;
      step_val_out <= 16'h0000;
      step_dwell_out <= 16'h0000;
      refused_out <= 1'b0;
    end else if (ce_in) begin
      step_valid_out <= 1'b0;
      refused_out <= 1'b0;
      if (abort_in) begin
        state <= R_IDLE;
        busy_out <= 1'b0;
      end else if (state == R_IDLE) begin
        if (start_in) begin
          state <= R_DIV;
          busy_out <= 1'b1;
          phase <= 1'b0;
          num <= {16'h0000, time_in};
          den <= {6'h00, count_in};
          rem <= 17'h00000;
          bitcnt <= 5'h00;
          n <= count_in;
          from_q <= from_in;
          to_q <= to_in;
        end else begin
          busy_out <= 1'b0;
        end
      end else if (dwell_bad || pt_last) begin
        state <= R_IDLE;
        refused_out <= dwell_bad;
        busy_out <= pt_last;
        step_valid_out <= pt_last;
        step_val_out <= pt_val[VAL_W-1:0];
      end else if (div_last) begin
        // Restart the divider for the next point: |to-from| * k / (n-1)
        if (!phase) begin
          step_dwell_out <= q_fin[DWELL_W-1:0];
        end else begin
          step_valid_out <= 1'b1;
          step_val_out <= pt_val[VAL_W-1:0];
        end
        k <= k_next;
        phase <= 1'b1;
        num <= val_num;
        den <= val_den;
        rem <= 17'h00000;
        bitcnt <= 5'h00;
      end else begin
        num <= q_fin;
        rem <= ge ? 17'(rem_sh - {1'b0, den}) : rem_sh;
        bitcnt <= 5'(bitcnt + 5'h01);
      end
    end
  end
endmodule
`default_nettype wire

// ### src/sls_sequencer.sv
// Setpoint list sequencer for one supply channel, with setpoint routing.
// Assumes synchronous command pulses, one cycle each, from the host side.
// Notes on behaviour
// - Table holds 1000 steps; refuse when full; an add in the cycle a ramp starts can push the count past 1000
// - Web dwell must lie in 0.1..5.0 s
// - Command-loaded dwell may be 0.01 s
// - Table kept until cleared by listed events
// - Started list: no additions, only erase; a ramp started in the execute cycle still writes its points
// - Protection, reset, limits, page exit erase table
// - Ramp dwell is time over count, >0.0005 s
// - Ramp points span start to end, constant limit
// - Loops 1..256, zero repeats forever
// - Running flag; execute acts as stop
// - After last loop hold final step values
// - Stop keeps output on, returns idle
// - Restart always begins at first entry
// - Reset stops, disables, zeroes setpoints, erases
// - Reject setpoints beyond model limits
// - Steps follow present operating mode
// - Main and limit loop follow mode
// - Voltage and current commands routed by mode
`timescale 1ns/1ns
`default_nettype none
module sls_sequencer
  import sls_pkg::*;
#(
  parameter int DWELL_TICK_CYC = TICK_CYC_DEF
)(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic mode_in,
  input wire logic [VAL_W-1:0] volt_max_in,
  input wire logic [VAL_W-1:0] curr_max_in,
  input wire logic set_volt_in,
  input wire logic set_curr_in,
  input wire logic [VAL_W-1:0] set_val_in,
  input wire logic out_on_in,
  input wire logic out_off_in,
  input wire logic add_step_in,
  input wire logic add_web_in,
  input wire logic [VAL_W-1:0] add_volt_in,
  input wire logic [VAL_W-1:0] add_curr_in,
  input wire logic [DWELL_W-1:0] add_dwell_in,
  input wire logic ramp_start_in,
  input wire logic [VAL_W-1:0] ramp_from_in,
  input wire logic [VAL_W-1:0] ramp_to_in,
  input wire logic [IDX_W-1:0] ramp_count_in,
  input wire logic [DWELL_W-1:0] ramp_time_in,
  input wire logic [VAL_W-1:0] ramp_limit_in,
  input wire logic [LOOP_W-1:0] loops_in,
  input wire logic exec_in,
  input wire logic clear_list_in,
  input wire logic power_off_in,
  input wire logic cal_in,
  input wire logic prot_change_in,
  input wire logic limit_change_in,
  input wire logic page_exit_in,
  input wire logic reset_cmd_in,
  output logic [VAL_W-1:0] main_set_out,
  output logic [VAL_W-1:0] limit_set_out,
  output logic output_en_out,
  output logic running_out,
  output logic [IDX_W-1:0] step_count_out,
  output logic [IDX_W-1:0] step_index_out,
  output logic add_refused_out,
  output logic set_refused_out,
  output logic ramp_refused_out,
  output logic ramp_busy_out
);
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_APPLY = 3'b010, S_DWELL = 3'b100} sls_state_t;
  localparam logic [15:0] TICK_LAST = 16'(DWELL_TICK_CYC - 1);
  sls_state_t state, next_state;
  logic mode_q, locked;
  logic [VAL_W-1:0] volt_set, curr_set, ramp_lim;
  logic [IDX_W-1:0] idx;
  logic [LOOP_W-1:0] loop_cnt, loops_q;
  logic [DWELL_W-1:0] dwell_left;
  logic [15:0] tick_cnt;
  logic [ENTRY_W-1:0] rd_entry;
  logic rg_busy, rg_valid, rg_refused;
  logic [VAL_W-1:0] rg_val;
  logic [DWELL_W-1:0] rg_dwell;

  // Any of these erases the table; a mode change is seen as a change of mode_in
  wire mode_chg = mode_in != mode_q;
  wire clr_list = clear_list_in | power_off_in | mode_chg | cal_in | prot_change_in
                  | limit_change_in | page_exit_in | reset_cmd_in;
  wire is_idle = state == S_IDLE;
  wire full = step_count_out == STEP_MAX;
  wire [VAL_W-1:0] main_lim = mode_q ? curr_max_in : volt_max_in;
  wire [VAL_W-1:0] comp_lim = mode_q ? volt_max_in : curr_max_in;
  wire web_dw_ok = add_dwell_in >= WEB_DWELL_MIN && add_dwell_in <= WEB_DWELL_MAX;
  wire cmd_dw_ok = add_dwell_in >= CMD_DWELL_MIN;
  wire add_lim_ok = sls_abs(add_volt_in) <= volt_max_in && sls_abs(add_curr_in) <= curr_max_in;
  wire add_ok_base = !clr_list && !locked && !full && add_lim_ok && !rg_busy;
  wire add_take = add_step_in && add_ok_base && (add_web_in ? web_dw_ok : cmd_dw_ok);
  wire [IDX_W:0] ramp_total = {1'b0, step_count_out} + {1'b0, ramp_count_in};
  wire ramp_t_ok = ramp_time_in >= WEB_DWELL_MIN && ramp_time_in <= WEB_DWELL_MAX;
  wire ramp_lim_ok = sls_abs(ramp_from_in) <= main_lim && sls_abs(ramp_to_in) <= main_lim
                     && sls_abs(ramp_limit_in) <= comp_lim;
  wire ramp_go = ramp_start_in && !rg_busy && !clr_list && !locked && ramp_count_in != 10'h000
                 && ramp_total <= {1'b0, STEP_MAX} && ramp_lim_ok && ramp_t_ok;
  wire ramp_wr = rg_valid && !clr_list;
  wire wr_en = add_take | ramp_wr;
  // Ramp points carry the main value of the present mode plus a fixed limit
  wire [VAL_W-1:0] wr_volt = ramp_wr ? (mode_q ? ramp_lim : rg_val) : add_volt_in;
  wire [VAL_W-1:0] wr_curr = ramp_wr ? (mode_q ? rg_val : ramp_lim) : add_curr_in;
  wire [DWELL_W-1:0] wr_dwell = ramp_wr ? rg_dwell : add_dwell_in;
  wire exec_go = exec_in && is_idle && step_count_out != 10'h000 && output_en_out
                 && !clr_list && !rg_busy && loops_in <= LOOP_MAX;
  wire stop_req = !is_idle && (exec_in || out_off_in);
  wire set_v_ok = set_volt_in && sls_abs(set_val_in) <= volt_max_in;
  wire set_c_ok = set_curr_in && sls_abs(set_val_in) <= curr_max_in;
  wire tick_end = tick_cnt == TICK_LAST;
  wire dwell_end = state == S_DWELL && tick_end && dwell_left == 16'h0001;
  wire last_step = idx == IDX_W'(step_count_out - 10'h001);
  wire [LOOP_W-1:0] loop_inc = LOOP_W'(loop_cnt + 9'h001);
  wire loop_last = loops_q != LOOP_CONT && loop_inc == loops_q;
  wire [VAL_W-1:0] next_main = mode_q ? curr_set : volt_set;
  wire [VAL_W-1:0] next_limit = mode_q ? volt_set : curr_set;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (exec_go) begin
          next_state = S_APPLY;
        end
      end
      S_APPLY: begin
        next_state = S_DWELL;
      end
      S_DWELL: begin
        if (dwell_end) begin
          next_state = (last_step && loop_last) ? S_IDLE : S_APPLY;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (clr_list || stop_req) begin
      next_state = S_IDLE;
    end
  end

  sls_step_table u_table (
    .ref_clk_in(ref_clk_in),
    .ce_in(ce_in),
    .wr_en_in(wr_en),
    .wr_idx_in(step_count_out),
    .wr_data_in({wr_volt, wr_curr, wr_dwell}),
    .rd_idx_in(idx),
    .rd_data_out(rd_entry)
  );

  sls_ramp_gen u_ramp (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .start_in(ramp_go),
    .abort_in(clr_list),
    .from_in(ramp_from_in),
    .to_in(ramp_to_in),
    .count_in(ramp_count_in),
    .time_in(ramp_time_in),
    .busy_out(rg_busy),
    .step_valid_out(rg_valid),
    .step_val_out(rg_val),
    .step_dwell_out(rg_dwell),
    .refused_out(rg_refused)
  );

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= S_IDLE;
      mode_q <= 1'b0;
      locked <= 1'b0;
      idx <= 10'h000;
      loop_cnt <= 9'h000;
      loops_q <= 9'h000;
      dwell_left <= 16'h0000;
      tick_cnt <= 16'h0000;
      ramp_lim <= 16'h0000;
      step_count_out <= 10'h000;
    end else if (ce_in) begin
      state <= next_state;
      mode_q <= mode_in;
      if (ramp_go) begin
        ramp_lim <= ramp_limit_in;
      end
      if (clr_list) begin
        step_count_out <= 10'h000;
        locked <= 1'b0;
      end else begin
        // An add in the execute cycle must not leave the list open for edits
        if (wr_en) begin
          step_count_out <= IDX_W'(step_count_out + 10'h001);
        end
        if (exec_go) begin
          locked <= 1'b1;
        end
      end
      if (exec_go) begin
        idx <= 10'h000;
        loop_cnt <= 9'h000;
        loops_q <= loops_in;
      end else if (dwell_end) begin
        idx <= last_step ? 10'h000 : IDX_W'(idx + 10'h001);
        loop_cnt <= last_step ? loop_inc : loop_cnt;
      end
      if (state == S_APPLY) begin
        dwell_left <= rd_entry[ENT_DWELL_LSB +: DWELL_W];
        tick_cnt <= 16'h0000;
      end else if (state == S_DWELL) begin
        tick_cnt <= tick_end ? 16'h0000 : 16'(tick_cnt + 16'h0001);
        dwell_left <= tick_end ? DWELL_W'(dwell_left - 16'h0001) : dwell_left;
      end
    end
  end

  // Setpoints, output enable and the registered view of them
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      volt_set <= VOLT_ZERO;
      curr_set <= CURR_MIN;
      output_en_out <= 1'b0;
      main_set_out <= VOLT_ZERO;
      limit_set_out <= CURR_MIN;
      running_out <= 1'b0;
      step_index_out <= 10'h000;
      add_refused_out <= 1'b0;
      set_refused_out <= 1'b0;
      ramp_refused_out <= 1'b0;
      ramp_busy_out <= 1'b0;
    end else if (ce_in) begin
      if (reset_cmd_in) begin
        volt_set <= VOLT_ZERO;
        curr_set <= CURR_MIN;
        output_en_out <= 1'b0;
      end else begin
        if (state == S_APPLY && !clr_list && !stop_req) begin
          volt_set <= rd_entry[ENT_VOLT_LSB +: VAL_W];
          curr_set <= rd_entry[ENT_CURR_LSB +: VAL_W];
        end else begin
          volt_set <= set_v_ok ? set_val_in : volt_set;
          curr_set <= set_c_ok ? set_val_in : curr_set;
        end
        output_en_out <= out_on_in ? 1'b1 : (out_off_in ? 1'b0 : output_en_out);
      end
      main_set_out <= next_main;
      limit_set_out <= next_limit;
      running_out <= next_state != S_IDLE;
      step_index_out <= idx;
      add_refused_out <= add_step_in && !add_take;
      set_refused_out <= (set_volt_in && !set_v_ok) || (set_curr_in && !set_c_ok);
      ramp_refused_out <= (ramp_start_in && !ramp_go) || rg_refused || (rg_busy && clr_list);
      ramp_busy_out <= rg_busy || ramp_go;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_table_cap_bound: assert property (step_count_out <= STEP_MAX)
    else $error("step count above table size");
  a_web_dwell_span: assert property (ce_in && add_step_in && add_web_in
      && (add_dwell_in < WEB_DWELL_MIN || add_dwell_in > WEB_DWELL_MAX)
      |=> add_refused_out && step_count_out <= $past(step_count_out))
    else $error("web step with bad dwell was taken");
  a_cmd_dwell_min: assert property (ce_in && add_step_in && !add_web_in
      && add_dwell_in == CMD_DWELL_MIN && add_ok_base
      |=> step_count_out == 10'($past(step_count_out) + 10'h001) && !add_refused_out)
    else $error("shortest command dwell was not taken");
  a_clear_empties: assert property (ce_in && clr_list
      |=> step_count_out == 10'h000 && !running_out)
    else $error("erase event left table or run");
  a_locked_no_add: assert property (ce_in && locked && add_step_in
      |=> add_refused_out && (step_count_out == $past(step_count_out) || step_count_out == 10'h000))
    else $error("step added to a started list");
  a_ramp_dwell_min: assert property (ce_in && ramp_start_in
      && {3'h0, ramp_time_in} < 19'({9'h000, ramp_count_in} * (32'(RAMP_DWELL_MIN) + 32'h1))
      |-> ##[1:40] ramp_refused_out)
    else $error("ramp with short step dwell not refused");
  a_exec_runs: assert property (ce_in && exec_go |=> running_out ##1 !ce_in || running_out
      || $past(stop_req) || $past(clr_list))
    else $error("accepted execute did not show running");
  a_stop_keeps_on: assert property (ce_in && running_out && exec_in && !clr_list
      && !out_off_in |=> !running_out && output_en_out)
    else $error("stop turned the output off or kept running");
  a_reset_zeroes: assert property (ce_in && reset_cmd_in ##1 ce_in
      |=> !output_en_out && main_set_out == VOLT_ZERO && limit_set_out == CURR_MIN)
    else $error("reset left output or setpoints");
  a_empty_exec_idle: assert property (ce_in && is_idle && exec_in
      && (step_count_out == 10'h000 || !output_en_out) |=> !running_out)
    else $error("execute started with empty table or output off");

  c_run_complete: cover property (running_out ##1 !running_out && output_en_out);
  c_ramp_loaded: cover property (ramp_busy_out ##1 !ramp_busy_out && step_count_out > 10'h001);
  c_table_full: cover property (step_count_out == STEP_MAX);
  c_stop_by_exec: cover property (running_out && exec_in && ce_in);
endmodule
`default_nettype wire

// ### src/sls_step_table.sv
// Step table storage: one write port, one asynchronous read port.
// Assumes the caller guards the write index against the table depth.
`timescale 1ns/1ns
`default_nettype none
module sls_step_table
  import sls_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [ENTRY_W-1:0] wr_data_in,
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [ENTRY_W-1:0] rd_data_out
);
  // Contents are volatile; emptiness is tracked by the caller's count
  logic [ENTRY_W-1:0] mem [0:TABLE_DEPTH-1];

  always_ff @(posedge ref_clk_in) begin
    if (ce_in && wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[rd_idx_in];
endmodule
`default_nettype wire

// ### tb/sls_host_model.sv
// Host side model: issues setpoint and step-entry commands as one-cycle pulses.
// Assumes the sequencer samples these on the rising edge of ref_clk_in.
`timescale 1ns/1ns
`default_nettype none
module sls_host_model
  import sls_pkg::*;
(
  input wire logic ref_clk_in,
  output logic set_volt_out,
  output logic set_curr_out,
  output logic [VAL_W-1:0] set_val_out,
  output logic add_step_out,
  output logic add_web_out,
  output logic [VAL_W-1:0] add_volt_out,
  output logic [VAL_W-1:0] add_curr_out,
  output logic [DWELL_W-1:0] add_dwell_out
);
  initial begin
    {set_volt_out, set_curr_out, add_step_out, add_web_out} = 4'h0;
    {set_val_out, add_volt_out, add_curr_out, add_dwell_out} = 64'h0;
  end
  // Limit is set once, then only the operating value moves
  task automatic set_cmd(input logic volt, input logic [VAL_W-1:0] val);
    @(posedge ref_clk_in);
    set_volt_out <= volt;
    set_curr_out <= ~volt;
    set_val_out <= val;
    @(posedge ref_clk_in);
    set_volt_out <= 1'b0;
    set_curr_out <= 1'b0;
  endtask
  // Web dwell kept in span except where a refusal is wanted
  task automatic add_cmd(input logic web, input logic [VAL_W-1:0] v, input logic [DWELL_W-1:0] d);
    @(posedge ref_clk_in);
    add_step_out <= 1'b1;
    add_web_out <= web;
    add_volt_out <= v;
    add_curr_out <= 16'h0032;
    add_dwell_out <= d;
    @(posedge ref_clk_in);
    add_step_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_setpoint_list_sequencer.sv
// Self-checking bench of the list sequencer, one task per scenario.
// Assumes a 100 MHz clock and a shortened dwell tick of 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_setpoint_list_sequencer;
  import sls_pkg::*;
  logic clk, nrst, mode, out_on, out_off, ramp_go, exec, clr, pwr_off, cal, prot, lim, page, rst_cmd;
  logic [VAL_W-1:0] r_from, r_to, r_lim, main_set, limit_set;
  logic [IDX_W-1:0] r_cnt, cnt, idx;
  logic [DWELL_W-1:0] r_time;
  logic [LOOP_W-1:0] loops;
  logic sv, sc, as, aw, oe, run, add_ref, set_ref, ramp_ref, ramp_busy, ce;
  logic [VAL_W-1:0] sval, av, ac;
  logic [DWELL_W-1:0] ad;
  int err_count = 0;
  int num_checks = 0;
  int i;
  sls_host_model host (.ref_clk_in(clk), .set_volt_out(sv), .set_curr_out(sc), .set_val_out(sval),
    .add_step_out(as), .add_web_out(aw), .add_volt_out(av), .add_curr_out(ac), .add_dwell_out(ad));
  sls_sequencer #(.DWELL_TICK_CYC(4)) uut (.ref_clk_in(clk), .nrst_in(nrst), .ce_in(ce),
    .mode_in(mode), .volt_max_in(16'h03E8), .curr_max_in(16'h01F4), .set_volt_in(sv),
    .set_curr_in(sc), .set_val_in(sval), .out_on_in(out_on), .out_off_in(out_off),
    .add_step_in(as), .add_web_in(aw), .add_volt_in(av), .add_curr_in(ac), .add_dwell_in(ad),
    .ramp_start_in(ramp_go), .ramp_from_in(r_from), .ramp_to_in(r_to), .ramp_count_in(r_cnt),
    .ramp_time_in(r_time), .ramp_limit_in(r_lim), .loops_in(loops), .exec_in(exec),
    .clear_list_in(clr), .power_off_in(pwr_off), .cal_in(cal), .prot_change_in(prot),
    .limit_change_in(lim), .page_exit_in(page), .reset_cmd_in(rst_cmd), .main_set_out(main_set),
    .limit_set_out(limit_set), .output_en_out(oe), .running_out(run), .step_count_out(cnt),
    .step_index_out(idx), .add_refused_out(add_ref), .set_refused_out(set_ref),
    .ramp_refused_out(ramp_ref), .ramp_busy_out(ramp_busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Pulse on exec or the stop path through the same control
  task automatic pulse_exec();
    @(posedge clk) exec <= 1'b1;
    @(posedge clk) exec <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    for (i = 0; i < 8000 && run !== 1'b0; i++) tick(1);
    chk("idle", 16'h0, 16'(run));
  endtask
  task automatic t_set();
    host.set_cmd(1'b1, 16'h0064);
    host.set_cmd(1'b0, 16'h0032);
    tick(3);
    chk("main", 16'h0064, main_set);
    chk("limit", 16'h0032, limit_set);
    host.set_cmd(1'b1, 16'h07D0);
    #1 chk("set_ref", 16'h1, 16'(set_ref));
    host.set_cmd(1'b1, 16'hFF9C);
    tick(3);
    chk("main_neg", 16'hFF9C, main_set);
    $display("t_set done");
  endtask
  task automatic t_add();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    host.add_cmd(1'b1, 16'h0010, 16'h03E8);
    host.add_cmd(1'b0, 16'h0020, 16'h0064);
    host.add_cmd(1'b1, 16'h0030, 16'h0064);
    #1 chk("web_short", 16'h1, 16'(add_ref));
    host.add_cmd(1'b0, 16'h0030, 16'h0063);
    #1 chk("cmd_short", 16'h1, 16'(add_ref));
    chk("count", 16'h2, 16'(cnt));
    pulse_exec();
    tick(1);
    chk("exec_off", 16'h0, 16'(run));
    $display("t_add done");
  endtask
  task automatic t_run();
    @(posedge clk) out_on <= 1'b1;
    @(posedge clk) out_on <= 1'b0;
    loops <= 9'h001;
    pulse_exec();
    chk("running", 16'h1, 16'(run));
    wait_idle();
    tick(3);
    chk("final", 16'h0020, main_set);
    chk("oe_hold", 16'h1, 16'(oe));
    host.add_cmd(1'b0, 16'h0040, 16'h0064);
    #1 chk("locked", 16'h1, 16'(add_ref));
    $display("t_run done");
  endtask
  task automatic t_stop();
    @(posedge clk) loops <= LOOP_CONT;
    pulse_exec();
    tick(20);
    chk("step0", 16'h0010, main_set);
    // Stop inside the second step, so that a restart from entry 0 is visible
    tick(4080);
    pulse_exec();
    tick(1);
    chk("stopped", 16'h0, 16'(run));
    chk("oe_on", 16'h1, 16'(oe));
    chk("held", 16'h0020, main_set);
    chk("stop_idx", 16'h1, 16'(idx));
    pulse_exec();
    tick(3);
    chk("restart", 16'h0, 16'(idx));
    chk("run_again", 16'h1, 16'(run));
    tick(4500);
    chk("loop_again", 16'h1, 16'(run));
    $display("t_stop done");
  endtask
  task automatic t_reset();
    @(posedge clk) rst_cmd <= 1'b1;
    @(posedge clk) rst_cmd <= 1'b0;
    tick(3);
    chk("rst_run", 16'h0, 16'(run));
    chk("rst_oe", 16'h0, 16'(oe));
    chk("rst_main", VOLT_ZERO, main_set);
    chk("rst_lim", CURR_MIN, limit_set);
    chk("rst_cnt", 16'h0, 16'(cnt));
    $display("t_reset done");
  endtask
  task automatic t_ramp();
    logic seen;
    seen = 1'b0;
    @(posedge clk) out_on <= 1'b1;
    {r_from, r_to, r_lim, r_time, r_cnt} <= {16'h0000, 16'h00C8, 16'h0064, 16'h03E8, 10'h0C8};
    @(posedge clk) {out_on, ramp_go} <= 2'b01;
    @(posedge clk) ramp_go <= 1'b0;
    for (i = 0; i < 100; i++) begin
      tick(1);
      seen = seen | ramp_ref;
    end
    chk("ramp_short", 16'h1, 16'(seen));
    @(posedge clk) r_cnt <= 10'h003;
    @(posedge clk) ramp_go <= 1'b1;
    @(posedge clk) ramp_go <= 1'b0;
    tick(2);
    chk("ramp_busy", 16'h1, 16'(ramp_busy));
    for (i = 0; i < 400 && ramp_busy !== 1'b0; i++) tick(1);
    chk("ramp_cnt", 16'h3, 16'(cnt));
    @(posedge clk) loops <= 9'h001;
    pulse_exec();
    wait_idle();
    tick(3);
    chk("ramp_end", 16'h00C8, main_set);
    chk("ramp_lim", 16'h0064, limit_set);
    $display("t_ramp done");
  endtask
  task automatic t_mode();
    @(posedge clk) mode <= 1'b1;
    tick(2);
    chk("mode_erase", 16'h0, 16'(cnt));
    host.set_cmd(1'b0, 16'h0020);
    tick(3);
    chk("cur_main", 16'h0020, main_set);
    $display("t_mode done");
  endtask
  task automatic t_erase();
    pulse_exec();
    tick(1);
    chk("exec_empty", 16'h0, 16'(run));
    for (int k = 0; k < 5; k++) begin
      host.add_cmd(1'b0, 16'h0010, 16'h0064);
      #1 chk("erase_pre", 16'h1, 16'(cnt));
      @(posedge clk) {ce, clr} <= 2'b01;
      @(posedge clk) {ce, clr, pwr_off, cal, prot, lim, page} <= {2'b10, 5'(5'h10 >> k)};
      #1 chk("ce_hold", 16'h1, 16'(cnt));
      @(posedge clk) {pwr_off, cal, prot, lim, page} <= 5'h00;
      tick(1);
      chk("erase", 16'h0, 16'(cnt));
    end
    @(posedge clk) out_off <= 1'b1;
    @(posedge clk) out_off <= 1'b0;
    tick(1);
    chk("oe_off", 16'h0, 16'(oe));
    $display("t_erase done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {nrst, mode, out_on, out_off, ramp_go, exec, clr, pwr_off, cal, prot, lim, page} = 12'h0;
    {rst_cmd, r_from, r_to, r_lim, r_time, r_cnt, loops} = 84'h0;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    tick(2);
    t_set();
    t_add();
    t_run();
    t_stop();
    t_reset();
    t_ramp();
    t_mode();
    t_erase();
    print_verdict();
  end
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
